// *** design/pwd_pkg.sv ***
// Package of constants and types for the pin-selectable watchdog supervisor
// Behaviour
// - Strobe stuck for a timeout pulses output
// - Counter clears on output or strobe edge
// - Timeout drives output low, then releases
// - Pulse width 100ms long, 1ms short
// - Equal variant: startup equals timeout table
// - Long variant: 60s startup, own timeout table
// - First-edge variant startup table, two first-edge codes
// - First-edge variant timeout table
// - Code 011 disables watchdog entirely
// - First-edge modes wait forever for strobe edge
// - Startup restarts at reset and select change
// - No countdown, no pulse during startup
// - After startup, count timeout and watch strobe
// - Output stays high while strobed in time
// - Only strobe levels held 100ns count
// - Strobe ignored during pulse and startup
// - Strobe ignored 300us after power-up or change
// - Disabled watchdog keeps output high
package pwd_pkg;

  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned CNT_W  = 34;

  typedef enum logic [1:0] {
    PWD_VAR_EQUAL = 2'b00,
    PWD_VAR_LONG  = 2'b01,
    PWD_VAR_EDGE  = 2'b10
  } pwd_variant_t;

  typedef enum logic [2:0] {
    PWD_ST_SETUP   = 3'b000,
    PWD_ST_STARTUP = 3'b001,
    PWD_ST_FIRST   = 3'b010,
    PWD_ST_WATCH   = 3'b011,
    PWD_ST_ALARM   = 3'b100,
    PWD_ST_OFF     = 3'b101
  } pwd_state_t;

  // Times in nanoseconds as printed
  localparam longint unsigned T_200US_NS = 64'd200_000;
  localparam longint unsigned T_30US_NS  = 64'd30_000;
  localparam longint unsigned T_1MS_NS   = 64'd1_000_000;
  localparam longint unsigned T_3MS_NS   = 64'd3_000_000;
  localparam longint unsigned T_10MS_NS  = 64'd10_000_000;
  localparam longint unsigned T_30MS_NS  = 64'd30_000_000;
  localparam longint unsigned T_100MS_NS = 64'd100_000_000;
  localparam longint unsigned T_300MS_NS = 64'd300_000_000;
  localparam longint unsigned T_1S_NS    = 64'd1_000_000_000;
  localparam longint unsigned T_3S_NS    = 64'd3_000_000_000;
  localparam longint unsigned T_10S_NS   = 64'd10_000_000_000;
  localparam longint unsigned T_60S_NS   = 64'd60_000_000_000;
  localparam longint unsigned T_SETUP_NS = 64'd300_000;
  localparam longint unsigned T_GLITCH_NS = 64'd100;
  localparam longint unsigned CLK_NS     = 64'd8;

  // Least times round up to whole cycles
  function automatic logic [CNT_W-1:0] ns2cyc(input longint unsigned ns);
    longint unsigned c;
    c = (ns + CLK_NS - 64'd1) / CLK_NS;
    if (c == 64'd0) c = 64'd1;
    return c[CNT_W-1:0];
  endfunction : ns2cyc

  localparam logic [CNT_W-1:0] CYC_200US = ns2cyc(T_200US_NS);
  localparam logic [CNT_W-1:0] CYC_30US  = ns2cyc(T_30US_NS);
  localparam logic [CNT_W-1:0] CYC_1MS   = ns2cyc(T_1MS_NS);
  localparam logic [CNT_W-1:0] CYC_3MS   = ns2cyc(T_3MS_NS);
  localparam logic [CNT_W-1:0] CYC_10MS  = ns2cyc(T_10MS_NS);
  localparam logic [CNT_W-1:0] CYC_30MS  = ns2cyc(T_30MS_NS);
  localparam logic [CNT_W-1:0] CYC_100MS = ns2cyc(T_100MS_NS);
  localparam logic [CNT_W-1:0] CYC_300MS = ns2cyc(T_300MS_NS);
  localparam logic [CNT_W-1:0] CYC_1S    = ns2cyc(T_1S_NS);
  localparam logic [CNT_W-1:0] CYC_3S    = ns2cyc(T_3S_NS);
  localparam logic [CNT_W-1:0] CYC_10S   = ns2cyc(T_10S_NS);
  localparam logic [CNT_W-1:0] CYC_60S   = ns2cyc(T_60S_NS);
  localparam logic [CNT_W-1:0] CYC_SETUP = ns2cyc(T_SETUP_NS);
  localparam logic [CNT_W-1:0] CYC_GLITCH = ns2cyc(T_GLITCH_NS);

  localparam logic [2:0] SEL_DISABLE = 3'h3;
  localparam logic [2:0] SEL_RESET   = 3'h0;

endpackage : pwd_pkg

// *** design/pwd_sync.sv ***
// Two-flop synchroniser with a hold filter for the strobe and select pins
`timescale 1ns/1ps
module pwd_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic [W-1:0]           pin_in,
  input  wire logic [pwd_pkg::CNT_W-1:0] hold_cyc,
  output logic      [W-1:0]           stable_q
);
  import pwd_pkg::*;

  logic [W-1:0]       s1_q, s2_q, s3_q, stable_d;
  logic [CNT_W-1:0]   hold_q, hold_d;

  always_comb begin
    stable_d = stable_q;
    hold_d   = hold_q;
    if (s2_q != s3_q) begin
      hold_d = '0;
    end else if (hold_q + 1'b1 >= hold_cyc) begin
      stable_d = s3_q;
    end else begin
      hold_d = hold_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_q     <= '0;
      s2_q     <= '0;
      s3_q     <= '0;
      hold_q   <= '0;
      stable_q <= '0;
    end else begin
      s1_q     <= pin_in;
      s2_q     <= s1_q;
      s3_q     <= s2_q;
      hold_q   <= hold_d;
      stable_q <= stable_d;
    end
  end

endmodule : pwd_sync

// *** design/pwd_watchdog.sv ***
// Top of the pin-selectable watchdog supervisor
`timescale 1ns/1ps
module pwd_watchdog #(
  parameter pwd_pkg::pwd_variant_t VARIANT   = pwd_pkg::PWD_VAR_EQUAL,
  parameter bit                    LONG_PULSE = 1'b1,
  parameter logic [pwd_pkg::CNT_W-1:0] SETUP_CYC = pwd_pkg::CYC_SETUP,
  parameter logic [pwd_pkg::CNT_W-1:0] PULSE_LONG_CYC = pwd_pkg::CYC_100MS,
  parameter logic [pwd_pkg::CNT_W-1:0] PULSE_SHORT_CYC = pwd_pkg::CYC_1MS,
  parameter int unsigned           TIME_DIV  = 1
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic kick_strobe_in,
  input  wire logic timing_select_lsb,
  input  wire logic timing_select_mid,
  input  wire logic timing_select_msb,
  output logic      timeout_pulse_n
);
  import pwd_pkg::*;

  logic [3:0]       pins_s;
  logic [2:0]       sel;
  logic             strobe;
  logic             strobe_prev_q, strobe_prev_d;
  logic [2:0]       sel_q, sel_d;
  logic [2:0]       pend_q, pend_d;
  logic             pend_v_q, pend_v_d;
  pwd_state_t       st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             out_n_q, out_n_d;
  logic             edge_seen;
  logic [CNT_W-1:0] t_start, t_wd, t_pulse;
  logic             first_edge;

  pwd_sync #(.W(4)) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_in   ({kick_strobe_in, timing_select_msb, timing_select_mid, timing_select_lsb}),
    .hold_cyc (CYC_GLITCH),
    .stable_q (pins_s)
  );

  assign sel    = pins_s[2:0];
  assign strobe = pins_s[3];
  // Strobe edges are taken from the filtered level only
  assign edge_seen = strobe != strobe_prev_q;

  function automatic logic [CNT_W-1:0] scale(input logic [CNT_W-1:0] c);
    logic [CNT_W-1:0] r;
    r = c / CNT_W'(TIME_DIV);
    return (r == '0) ? CNT_W'(1) : r;
  endfunction : scale

  // Table lookup of startup and timeout for the active code
  always_comb begin
    t_start    = CYC_1MS;
    t_wd       = CYC_1MS;
    first_edge = 1'b0;
    case (VARIANT)
      PWD_VAR_EQUAL: begin
        case (sel_q)
          3'h0: t_wd = CYC_1MS;
          3'h1: t_wd = CYC_10MS;
          3'h2: t_wd = CYC_30MS;
          3'h4: t_wd = CYC_100MS;
          3'h5: t_wd = CYC_1S;
          3'h6: t_wd = CYC_10S;
          default: t_wd = CYC_60S;
        endcase
        t_start = t_wd;
      end
      PWD_VAR_LONG: begin
        t_start = CYC_60S;
        case (sel_q)
          3'h0: t_wd = CYC_1MS;
          3'h1: t_wd = CYC_3MS;
          3'h2: t_wd = CYC_10MS;
          3'h4: t_wd = CYC_100MS;
          3'h5: t_wd = CYC_300MS;
          3'h6: t_wd = CYC_3S;
          default: t_wd = CYC_60S;
        endcase
      end
      default: begin
        case (sel_q)
          3'h0: begin
            t_start = CYC_3MS;
            t_wd    = CYC_3MS;
          end
          3'h1: begin
            t_start = CYC_3S;
            t_wd    = CYC_3S;
          end
          3'h2: begin
            t_start = CYC_60S;
            t_wd    = CYC_1S;
          end
          3'h4: begin
            t_start = CYC_200US;
            t_wd    = CYC_30US;
          end
          3'h5: begin
            first_edge = 1'b1;
            t_wd       = CYC_1S;
          end
          3'h6: begin
            first_edge = 1'b1;
            t_wd       = CYC_10S;
          end
          default: begin
            t_start = CYC_60S;
            t_wd    = CYC_10S;
          end
        endcase
      end
    endcase
    t_start = scale(t_start);
    t_wd    = scale(t_wd);
  end

  assign t_pulse = LONG_PULSE ? PULSE_LONG_CYC : PULSE_SHORT_CYC;

  assign timeout_pulse_n = out_n_q;

  // Phase sequencer: setup, startup or first edge, watch, pulse
  always_comb begin
    st_d          = st_q;
    cnt_d         = cnt_q;
    out_n_d       = 1'b1;
    sel_d         = sel_q;
    pend_d        = pend_q;
    pend_v_d      = pend_v_q;
    strobe_prev_d = strobe;
    // A code change during a pulse waits for the pulse to finish
    if (sel != sel_q && st_q == PWD_ST_ALARM) begin
      pend_d   = sel;
      pend_v_d = 1'b1;
    end
    case (st_q)
      PWD_ST_SETUP: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q + 1'b1 >= SETUP_CYC) begin
          cnt_d = '0;
          if (sel_q == SEL_DISABLE) st_d = PWD_ST_OFF;
          else if (first_edge) st_d = PWD_ST_FIRST;
          else st_d = PWD_ST_STARTUP;
        end
      end
      PWD_ST_STARTUP: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q + 1'b1 >= t_start) begin
          cnt_d = '0;
          st_d  = PWD_ST_WATCH;
        end
      end
      PWD_ST_FIRST: begin
        cnt_d = '0;
        if (edge_seen) st_d = PWD_ST_WATCH;
      end
      PWD_ST_WATCH: begin
        if (edge_seen) begin
          cnt_d = '0;
        end else if (cnt_q + 1'b1 >= t_wd) begin
          cnt_d   = '0;
          st_d    = PWD_ST_ALARM;
          out_n_d = 1'b0;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      PWD_ST_ALARM: begin
        out_n_d = 1'b0;
        cnt_d   = cnt_q + 1'b1;
        if (cnt_q + 1'b1 >= t_pulse) begin
          cnt_d   = '0;
          out_n_d = 1'b1;
          if (pend_v_q || pend_v_d) begin
            sel_d    = pend_v_d ? pend_d : pend_q;
            pend_v_d = 1'b0;
            st_d     = PWD_ST_SETUP;
          end else begin
            st_d = PWD_ST_WATCH;
          end
        end
      end
      PWD_ST_OFF: begin
        cnt_d = '0;
      end
      default: begin
        st_d  = PWD_ST_SETUP;
        cnt_d = '0;
      end
    endcase
    // Code change outside a pulse restarts the setup phase at once
    if (sel != sel_q && st_q != PWD_ST_ALARM) begin
      sel_d   = sel;
      st_d    = PWD_ST_SETUP;
      cnt_d   = '0;
      out_n_d = 1'b1;
    end
  end

  // State registers; the output is taken straight from out_n_q
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q            <= PWD_ST_SETUP;
      cnt_q           <= '0;
      out_n_q         <= 1'b1;
      sel_q           <= SEL_RESET;
      pend_q          <= SEL_RESET;
      pend_v_q        <= 1'b0;
      strobe_prev_q   <= 1'b0;
    end else begin
      st_q            <= st_d;
      cnt_q           <= cnt_d;
      out_n_q         <= out_n_d;
      sel_q           <= sel_d;
      pend_q          <= pend_d;
      pend_v_q        <= pend_v_d;
      strobe_prev_q   <= strobe_prev_d;
    end
  end

endmodule : pwd_watchdog

// *** dv/pwd_chk.sv ***
// Checker of watchdog output timing
`timescale 1ns/1ps
module pwd_chk #(
  parameter logic [pwd_pkg::CNT_W-1:0] SETUP_CYC      = 34'h14,
  parameter logic [pwd_pkg::CNT_W-1:0] PULSE_LONG_CYC = 34'h32,
  parameter int unsigned               TIME_DIV       = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic kick_strobe_in,
  input wire logic timing_select_lsb,
  input wire logic timing_select_mid,
  input wire logic timing_select_msb,
  input wire logic timeout_pulse_n
);
  import pwd_pkg::*;
  localparam int S = int'(SETUP_CYC);
  localparam int P = int'(PULSE_LONG_CYC);
  localparam int WD [8] = '{int'(CYC_1MS / TIME_DIV), int'(CYC_10MS / TIME_DIV),
    int'(CYC_30MS / TIME_DIV), 0, int'(CYC_100MS / TIME_DIV), int'(CYC_1S / TIME_DIV),
    int'(CYC_10S / TIME_DIV), int'(CYC_60S / TIME_DIV)};
  logic [2:0] sel, sel_q;
  logic       k_q, flt_q, flt_d, kick;
  logic [3:0] lv_q, lv_d;
  int         sa_q, sa_d, ka_q, ka_d, hi_q, hi_d, lo_q, lo_d, wd;
  assign sel = {timing_select_msb, timing_select_mid, timing_select_lsb};
  assign wd  = WD[sel];
  // A kick is a new level held for the minimum strobe width
  always_comb begin
    lv_d  = (kick_strobe_in != k_q) ? 4'h0 : lv_q + 4'(lv_q != 4'hF);
    kick  = (lv_q == 4'hC) && (k_q != flt_q);
    flt_d = kick ? k_q : flt_q;
    ka_d  = kick ? 0 : ka_q + 1;
    sa_d  = (sel != sel_q) ? 0 : sa_q + 1;
    hi_d  = timeout_pulse_n ? hi_q + 1 : 0;
    lo_d  = timeout_pulse_n ? 0 : lo_q + 1;
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {sel_q, k_q, flt_q, lv_q} <= '0;
      {sa_q, ka_q, hi_q, lo_q} <= '0;
    end else begin
      {sel_q, k_q, flt_q, lv_q} <= {sel, kick_strobe_in, flt_d, lv_d};
      {sa_q, ka_q, hi_q, lo_q} <= {sa_d, ka_d, hi_d, lo_d};
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_PW: assert property ($rose(timeout_pulse_n) |-> lo_q == P)
    else $error("pulse width wrong");
  AST_REL: assert property (lo_q <= P)
    else $error("pulse not released");
  AST_DIS: assert property (sel == SEL_DISABLE && sa_q > S + P + 40 |-> timeout_pulse_n)
    else $error("pulse while disabled");
  AST_SU: assert property ($fell(timeout_pulse_n) |-> sa_q > S + 2 * wd)
    else $error("pulse in startup");
  AST_KICK: assert property ($fell(timeout_pulse_n) |-> ka_q >= wd)
    else $error("pulse despite kick");
  AST_STUCK: assert property (sel != SEL_DISABLE && sa_q > S + 3 * wd + 60
    && ka_q > wd + P + 30 |-> hi_q < ka_q)
    else $error("missing pulse");
  AST_GAP: assert property ($fell(timeout_pulse_n) |-> hi_q >= wd)
    else $error("pulses too close");
  AST_HI: assert property ($rose(timeout_pulse_n) && wd > 8 |=> timeout_pulse_n [*8])
    else $error("output low after release");
endmodule : pwd_chk
bind pwd_watchdog pwd_chk #(.SETUP_CYC(SETUP_CYC), .PULSE_LONG_CYC(PULSE_LONG_CYC),
  .TIME_DIV(TIME_DIV)) chk_u (.core_clk(core_clk), .rst(rst),
  .kick_strobe_in(kick_strobe_in), .timing_select_lsb(timing_select_lsb),
  .timing_select_mid(timing_select_mid), .timing_select_msb(timing_select_msb),
  .timeout_pulse_n(timeout_pulse_n));

// *** dv/pwd_cpu.sv ***
// Processor model toggling the strobe
`timescale 1ns/1ps
module pwd_cpu (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        run,
  input  wire logic        glitch,
  input  wire logic [15:0] per,
  output logic             kick_strobe_in
);
  logic [15:0] cnt_q, cnt_d;
  logic        lvl_q, lvl_d;
  always_comb begin
    cnt_d = (cnt_q >= per) ? 16'h0 : cnt_q + 16'h1;
    lvl_d = lvl_q ^ (run && cnt_q >= per);
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {cnt_q, lvl_q} <= '0;
    end else begin
      {cnt_q, lvl_q} <= {cnt_d, lvl_d};
    end
  end
  // Glitch mode emits pulses shorter than the minimum width on purpose
  assign kick_strobe_in = lvl_q ^ (glitch && cnt_q < 16'h5);
endmodule : pwd_cpu

// *** dv/pwd_watchdog_test.sv ***
// Self-checking bench for the watchdog supervisor
`timescale 1ns/1ps
module pwd_watchdog_test;
  import pwd_pkg::*;
  localparam int S = 20;
  localparam int P = 50;
  logic        core_clk, rst, run, glitch, o, k;
  logic [2:0]  sel;
  logic [15:0] per, lfsr;
  int          bad_count, n_compared, cyc, np, hi, lo, gap, wlo, n0;
  pwd_cpu cpu_u (.core_clk(core_clk), .rst(rst), .run(run), .glitch(glitch), .per(per),
    .kick_strobe_in(k));
  pwd_watchdog #(.VARIANT(PWD_VAR_EQUAL), .LONG_PULSE(1'b1), .SETUP_CYC(34'h14),
    .PULSE_LONG_CYC(34'h32), .PULSE_SHORT_CYC(34'hA), .TIME_DIV(32'h1E848)) dut_u (
    .core_clk(core_clk), .rst(rst), .kick_strobe_in(k), .timing_select_lsb(sel[0]),
    .timing_select_mid(sel[1]), .timing_select_msb(sel[2]), .timeout_pulse_n(o));
  function automatic int exp_wd(input logic [2:0] c);
    int t [8] = '{1, 10, 30, 0, 100, 1000, 10000, 60000};
    return t[c];
  endfunction : exp_wd
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nxt
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %0d expected %0d", $time, seen, exp);
    end
  endtask : chk
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task wait_np(input int n);
    int t;
    t = 0;
    while (np < n && t < 40000) begin
      @(posedge core_clk);
      t++;
    end
    if (np < n) begin
      bad_count++;
      $display("Error at %0t: no pulse within the wait limit", $time);
      end_sim();
    end
  endtask : wait_np
  // Changing the code inside a pulse keeps a stale-code pulse from racing the change
  task set_sel(input logic [2:0] c, input bit wait_low);
    wait_np(wait_low ? np + 1 : 0);
    @(posedge core_clk);
    sel <= c;
    n0 = np;
  endtask : set_sel
  task stuck(input logic [2:0] c);
    run <= 1'b0;
    set_sel(c, 1'b1);
    wait_np(n0 + 2);
    chk(wlo, P);
    chk(gap >= exp_wd(c) && gap <= exp_wd(c) + 3, 1);
    $display("stuck test code %0d done", c);
  endtask : stuck
  task kicked(input logic [2:0] c);
    set_sel(c, 1'b1);
    lfsr = nxt(lfsr);
    per <= 16'(14 + int'(lfsr) % (exp_wd(c) / 2));
    run <= 1'b1;
    repeat ((exp_wd(c) > 1000) ? 3000 : S + 3 * exp_wd(c) + 100) @(posedge core_clk);
    chk(np, n0);
    $display("kicked test code %0d done", c);
  endtask : kicked
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(negedge core_clk) begin
    cyc++;
    if (rst) begin
      hi = 0;
      lo = 0;
    end else if (o === 1'b0) begin
      if (lo == 0) begin
        np++;
        gap = hi;
      end
      lo++;
      hi = 0;
    end else begin
      if (lo != 0) wlo = lo;
      lo = 0;
      hi++;
    end
    if (cyc == 90000) begin
      bad_count++;
      $display("Error at %0t: run exceeded its cycle limit", $time);
      end_sim();
    end
  end
  initial begin
    {rst, run, glitch, per, sel, lfsr} = {3'b100, 16'hE, 3'h1, 16'h1A05};
    {bad_count, n_compared, cyc, np, hi, lo, gap, wlo, n0} = '0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    wait_np(1);
    stuck(3'h2);
    stuck(3'h0);
    stuck(3'h1);
    kicked(3'h4);
    stuck(3'h4);
    glitch <= 1'b1;
    stuck(3'h4);
    glitch <= 1'b0;
    kicked(3'h5);
    stuck(3'h5);
    kicked(3'h7);
    set_sel(SEL_DISABLE, 1'b0);
    run <= 1'b0;
    repeat (S + P + 2000) @(posedge core_clk);
    chk(np, n0);
    $display("disable test done");
    set_sel(3'h6, 1'b0);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    wait_np(n0 + 1);
    chk(gap >= S + 2 * exp_wd(3'h6), 1);
    $display("reset test done");
    end_sim();
  end
endmodule : pwd_watchdog_test
